//--- rtl/ddpu_pkg.sv
/*
 * ddpu_pkg: constants and carrier types for the dual data pointer unit.
 * Assumes an 8-bit special-register bus with 8-bit addresses on the core clock.
 */
package ddpu_pkg;
    // special-register addresses
    localparam logic [7:0] DDPU_ADDR_PTR_LO = 8'h82;
    localparam logic [7:0] DDPU_ADDR_PTR_HI = 8'h83;
    localparam logic [7:0] DDPU_ADDR_CTRL = 8'h85;
    localparam logic [7:0] DDPU_ADDR_MODE = 8'h86;
    // reset values
    localparam logic [7:0] DDPU_CTRL_RESET = 8'h00;
    localparam logic [7:0] DDPU_MODE_RESET = 8'h00;
    localparam logic [15:0] DDPU_PTR_RESET = 16'h0000;
    localparam logic [15:0] DDPU_PTR_ONE = 16'h0001;
    // field positions
    localparam int DDPU_CTRL_SEL_BIT = 0;
    localparam int DDPU_CTRL_SWAP_BIT = 6;
    localparam int DDPU_MODE_A_LSB = 0;
    localparam int DDPU_MODE_B_LSB = 2;
    localparam logic [7:0] DDPU_CTRL_RW_MASK = 8'h41;
    localparam logic [7:0] DDPU_MODE_RW_MASK = 8'h0F;

    // step codes of a two-bit mode field
    typedef enum logic [1:0] {
        DDPU_STEP_HOLD = 2'h0,
        DDPU_STEP_RSVD = 2'h1,
        DDPU_STEP_INC = 2'h2,
        DDPU_STEP_DEC = 2'h3
    } ddpu_step_t;

    // special-register bus request
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } ddpu_sfr_req_t;

    // pointer-use events from instruction execution
    typedef struct packed {
        logic extMove; // external-data move through the standard pointer
        logic otherUse; // code-byte move, indirect jump and other uses
    } ddpu_use_t;
endpackage

//--- rtl/ddpu_stepper.sv
/*
 * ddpu_stepper: computes one pointer's value after an external-data move.
 * Assumes the caller decides whether the step is applied.
 */
`timescale 1ns/1ps
module ddpu_stepper
    import ddpu_pkg::*;
(
    // pointer in and out
    input wire logic [15:0] ptrIn,
    output logic [15:0] ptrOut,
    // mode field
    input wire ddpu_pkg::ddpu_step_t stepMode
);
    // wraps naturally modulo 2^16; reserved code holds
    always_comb begin
        case (stepMode)
            DDPU_STEP_INC: ptrOut = ptrIn + DDPU_PTR_ONE;
            DDPU_STEP_DEC: ptrOut = ptrIn - DDPU_PTR_ONE;
            default: ptrOut = ptrIn;
        endcase
    end
endmodule

//--- rtl/ddpu_read_mux.sv
/*
 * ddpu_read_mux: read-data selection for the unit's special registers.
 * Assumes one read address at a time; unmapped addresses read zero.
 */
`timescale 1ns/1ps
module ddpu_read_mux
    import ddpu_pkg::*;
(
    // address and sources
    input wire logic [7:0] addr,
    input wire logic [15:0] activePtr,
    input wire logic [7:0] ctrl,
    input wire logic [7:0] mode,
    // result
    output logic [7:0] rdata,
    output logic hit
);
    // only the selected pointer can be seen here
    always_comb begin
        hit = 1'b1;
        case (addr)
            DDPU_ADDR_PTR_LO: rdata = activePtr[7:0];
            DDPU_ADDR_PTR_HI: rdata = activePtr[15:8];
            DDPU_ADDR_CTRL: rdata = ctrl & DDPU_CTRL_RW_MASK;
            DDPU_ADDR_MODE: rdata = mode & DDPU_MODE_RW_MASK;
            default: begin
                rdata = 8'h00;
                hit = 1'b0;
            end
        endcase
    end
endmodule

//--- rtl/dual_data_pointer_unit.sv
/*
 * dual_data_pointer_unit: two background 16-bit external-data pointers, one
 * shown at the standard pointer addresses, with auto-step and auto-swap.
 * Assumes the core issues at most one register access or pointer use per
 * cycle, all synchronous to core_clk, with a synchronous active-high reset.
 */
`timescale 1ns/1ps
module dual_data_pointer_unit
    import ddpu_pkg::*;
#(
    parameter int PTR_W = 16
)
(
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // special-register bus
    input wire ddpu_pkg::ddpu_sfr_req_t sfrReq,
    output logic [7:0] sfrRdata,
    output logic sfrHit,
    // pointer use from instruction execution
    input wire ddpu_pkg::ddpu_use_t ptrUse,
    // standard pointer value for address generation
    output logic [PTR_W-1:0] standardPointerWindow,
    output logic activePointerSelect
);
    ////////////////////////////////////////////////////////////////////
    // state
    logic [PTR_W-1:0] pointerA_r, pointerA_nxt;
    logic [PTR_W-1:0] pointerB_r, pointerB_nxt;
    logic [7:0] pointerControl_r, pointerControl_nxt;
    logic [7:0] pointerStepMode_r, pointerStepMode_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic hit_r, hit_nxt;

    logic selB;
    logic autoSwapEnable;
    logic [PTR_W-1:0] activePtr;
    logic [PTR_W-1:0] steppedA, steppedB;
    logic [7:0] muxData;
    logic muxHit;
    logic wrLo, wrHi, wrCtrl, wrMode;

    assign selB = pointerControl_r[DDPU_CTRL_SEL_BIT];
    assign autoSwapEnable = pointerControl_r[DDPU_CTRL_SWAP_BIT];
    assign activePtr = selB ? pointerB_r : pointerA_r;
    assign standardPointerWindow = activePtr;
    assign activePointerSelect = selB;

    // write strobes
    assign wrLo = sfrReq.wr && (sfrReq.addr == DDPU_ADDR_PTR_LO);
    assign wrHi = sfrReq.wr && (sfrReq.addr == DDPU_ADDR_PTR_HI);
    assign wrCtrl = sfrReq.wr && (sfrReq.addr == DDPU_ADDR_CTRL);
    assign wrMode = sfrReq.wr && (sfrReq.addr == DDPU_ADDR_MODE);

    ////////////////////////////////////////////////////////////////////
    // step arithmetic, one per pointer
    ddpu_stepper u_stepA (
        .ptrIn(pointerA_r),
        .ptrOut(steppedA),
        .stepMode(ddpu_step_t'(pointerStepMode_r[DDPU_MODE_A_LSB +: 2]))
    );
    ddpu_stepper u_stepB (
        .ptrIn(pointerB_r),
        .ptrOut(steppedB),
        .stepMode(ddpu_step_t'(pointerStepMode_r[DDPU_MODE_B_LSB +: 2]))
    );

    ddpu_read_mux u_rmux (
        .addr(sfrReq.addr),
        .activePtr(activePtr),
        .ctrl(pointerControl_r),
        .mode(pointerStepMode_r),
        .rdata(muxData),
        .hit(muxHit)
    );

    ////////////////////////////////////////////////////////////////////
    // pointer next values; a software write wins its byte over a step in the
    // same cycle because its assignment comes after the step below
    always_comb begin
        pointerA_nxt = pointerA_r;
        pointerB_nxt = pointerB_r;
        if (ptrUse.extMove) begin
            // only the selected pointer steps
            if (selB) begin
                pointerB_nxt = steppedB;
            end else begin
                pointerA_nxt = steppedA;
            end
        end
        if (wrLo) begin
            if (selB) begin
                pointerB_nxt[7:0] = sfrReq.wdata;
            end else begin
                pointerA_nxt[7:0] = sfrReq.wdata;
            end
        end
        if (wrHi) begin
            if (selB) begin
                pointerB_nxt[15:8] = sfrReq.wdata;
            end else begin
                pointerA_nxt[15:8] = sfrReq.wdata;
            end
        end
    end

    // control and mode next values
    always_comb begin
        pointerControl_nxt = pointerControl_r;
        pointerStepMode_nxt = pointerStepMode_r;
        // swap uses the select seen by this move, so the step above hit
        // the used pointer before the flip takes effect
        if (ptrUse.extMove && autoSwapEnable) begin
            pointerControl_nxt[DDPU_CTRL_SEL_BIT] = ~selB;
        end
        if (wrCtrl) begin
            pointerControl_nxt = sfrReq.wdata & DDPU_CTRL_RW_MASK;
        end
        if (wrMode) begin
            pointerStepMode_nxt = sfrReq.wdata & DDPU_MODE_RW_MASK;
        end
    end

    // registered read data, valid the cycle after the read
    always_comb begin
        rdata_nxt = sfrReq.rd ? muxData : 8'h00;
        hit_nxt = sfrReq.rd && muxHit;
    end

    ////////////////////////////////////////////////////////////////////
    // registers
    always_ff @(posedge core_clk) begin
        if (reset) begin
            pointerA_r <= DDPU_PTR_RESET;
            pointerB_r <= DDPU_PTR_RESET;
            pointerControl_r <= DDPU_CTRL_RESET;
            pointerStepMode_r <= DDPU_MODE_RESET;
            rdata_r <= 8'h00;
            hit_r <= 1'b0;
        end else begin
            pointerA_r <= pointerA_nxt;
            pointerB_r <= pointerB_nxt;
            pointerControl_r <= pointerControl_nxt;
            pointerStepMode_r <= pointerStepMode_nxt;
            rdata_r <= rdata_nxt;
            hit_r <= hit_nxt;
        end
    end

    assign sfrRdata = rdata_r;
    assign sfrHit = hit_r;

    ////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    sequence s_moveA_inc;
        ptrUse.extMove && !selB && !sfrReq.wr && pointerStepMode_r[1:0] == DDPU_STEP_INC;
    endsequence

    a_reset_select_clear: assert property ($rose(!reset) |-> !activePointerSelect)
        else $error("select not clear after reset");
    a_window_shows_sel: assert property (standardPointerWindow == (selB ? pointerB_r : pointerA_r))
        else $error("window does not show selected pointer");
    a_step_a_inc: assert property (s_moveA_inc |=> pointerA_r == $past(pointerA_r) + DDPU_PTR_ONE)
        else $error("pointer A did not increment");
    a_step_b_dec: assert property (ptrUse.extMove && selB && !sfrReq.wr
        && pointerStepMode_r[3:2] == DDPU_STEP_DEC |=> pointerB_r == $past(pointerB_r) - DDPU_PTR_ONE)
        else $error("pointer B did not decrement");
    a_background_hold: assert property (!sfrReq.wr && !selB |=> $stable(pointerB_r))
        else $error("background pointer changed");
    a_other_use_hold: assert property (ptrUse.otherUse && !ptrUse.extMove && !sfrReq.wr
        |=> $stable(pointerA_r) && $stable(pointerB_r))
        else $error("pointer stepped on non-move use");
    a_auto_swap_flip: assert property (ptrUse.extMove && autoSwapEnable && !sfrReq.wr
        |=> activePointerSelect != $past(activePointerSelect))
        else $error("auto swap did not flip select");
    a_no_swap_manual: assert property (ptrUse.extMove && !autoSwapEnable && !sfrReq.wr
        |=> $stable(activePointerSelect))
        else $error("select flipped without auto swap");
    a_reserved_hold: assert property (ptrUse.extMove && !selB && !sfrReq.wr
        && pointerStepMode_r[1:0] == DDPU_STEP_RSVD |=> $stable(pointerA_r))
        else $error("reserved code changed pointer");
    a_ctrl_reserved_zero: assert property (pointerControl_r == (pointerControl_r & DDPU_CTRL_RW_MASK)
        && pointerStepMode_r[7:4] == 4'h0)
        else $error("reserved bits set");

    ////////////////////////////////////////////////////////////////////
    // further checks: step codes, swap order, window writes, read path
    // byte views of the window, so that $past sees plain signals
    logic [7:0] winLo;
    logic [7:0] winHi;
    assign winLo = activePtr[7:0];
    assign winHi = activePtr[15:8];

    // moves of one pointer with a given step code and no write alongside;
    // a write in the same cycle would win its byte and mask the step
    sequence s_moveA_dec;
        ptrUse.extMove && !selB && !sfrReq.wr && pointerStepMode_r[1:0] == DDPU_STEP_DEC;
    endsequence

    sequence s_moveB_inc;
        ptrUse.extMove && selB && !sfrReq.wr && pointerStepMode_r[3:2] == DDPU_STEP_INC;
    endsequence

    sequence s_moveB_hold;
        ptrUse.extMove && selB && !sfrReq.wr
            && (pointerStepMode_r[3:2] == DDPU_STEP_HOLD || pointerStepMode_r[3:2] == DDPU_STEP_RSVD);
    endsequence

    // a move that also swaps: the step must land on the pointer the move
    // used, not on the one that the flipped select shows afterwards
    sequence s_swap_from_a;
        s_moveA_inc ##0 autoSwapEnable;
    endsequence

    sequence s_swap_from_b;
        s_moveB_inc ##0 autoSwapEnable;
    endsequence

    // register reads, answered from flops one cycle later
    sequence s_read_ctrl;
        sfrReq.rd && sfrReq.addr == DDPU_ADDR_CTRL;
    endsequence

    sequence s_read_mode;
        sfrReq.rd && sfrReq.addr == DDPU_ADDR_MODE;
    endsequence

    // step codes not covered above
    a_step_a_dec: assert property (s_moveA_dec
        |=> pointerA_r == $past(pointerA_r) - DDPU_PTR_ONE)
        else $error("pointer A did not decrement");
    a_step_b_inc: assert property (s_moveB_inc
        |=> pointerB_r == $past(pointerB_r) + DDPU_PTR_ONE)
        else $error("pointer B did not increment");
    a_step_b_hold: assert property (s_moveB_hold
        |=> $stable(pointerB_r))
        else $error("pointer B moved on hold code");

    // step first, then swap, in one edge
    a_swap_after_a: assert property (s_swap_from_a
        |=> selB && pointerA_r == $past(pointerA_r) + DDPU_PTR_ONE)
        else $error("swap from A out of order");
    a_swap_after_b: assert property (s_swap_from_b
        |=> !selB && pointerB_r == $past(pointerB_r) + DDPU_PTR_ONE)
        else $error("swap from B out of order");

    // background and idle pointers stay put
    a_foreground_b_hold: assert property (!sfrReq.wr && selB
        |=> $stable(pointerA_r))
        else $error("background pointer A changed");
    a_idle_pointers_hold: assert property (!ptrUse.extMove && !wrLo && !wrHi
        |=> $stable(pointerA_r) && $stable(pointerB_r))
        else $error("pointer changed without move or write");

    // window writes reach only the selected pointer
    a_write_lo_lands: assert property (wrLo && !ptrUse.extMove
        |=> winLo == $past(sfrReq.wdata))
        else $error("low byte write lost");
    a_write_hi_lands: assert property (wrHi && !ptrUse.extMove
        |=> winHi == $past(sfrReq.wdata))
        else $error("high byte write lost");
    a_write_bg_a_hold: assert property ((wrLo || wrHi) && selB
        |=> $stable(pointerA_r))
        else $error("window write reached pointer A");
    a_write_bg_b_hold: assert property ((wrLo || wrHi) && !selB
        |=> $stable(pointerB_r))
        else $error("window write reached pointer B");

    // control and mode writes; a control write beats an auto-swap
    a_ctrl_write_wins: assert property (wrCtrl
        |=> pointerControl_r == ($past(sfrReq.wdata) & DDPU_CTRL_RW_MASK))
        else $error("control write not applied");
    a_mode_write_lands: assert property (wrMode
        |=> pointerStepMode_r == ($past(sfrReq.wdata) & DDPU_MODE_RW_MASK))
        else $error("mode write not applied");

    // read answers one cycle after the strobe
    a_read_ctrl_answer: assert property (s_read_ctrl
        |=> sfrHit && sfrRdata == $past(pointerControl_r))
        else $error("control read wrong");
    a_read_mode_answer: assert property (s_read_mode
        |=> sfrHit && sfrRdata == $past(pointerStepMode_r))
        else $error("mode read wrong");
    a_read_ptr_lo: assert property (sfrReq.rd && sfrReq.addr == DDPU_ADDR_PTR_LO
        |=> sfrHit && sfrRdata == $past(winLo))
        else $error("low byte read wrong");
    a_read_ptr_hi: assert property (sfrReq.rd && sfrReq.addr == DDPU_ADDR_PTR_HI
        |=> sfrHit && sfrRdata == $past(winHi))
        else $error("high byte read wrong");
    a_unmapped_read: assert property (sfrReq.rd && !muxHit
        |=> !sfrHit && sfrRdata == 8'h00)
        else $error("unmapped read answered");

    // reset itself is checked here, so the default disable is overridden
    a_reset_values: assert property (disable iff (1'b0) reset
        |=> !activePointerSelect && pointerControl_r == DDPU_CTRL_RESET && pointerStepMode_r == DDPU_MODE_RESET)
        else $error("registers not at reset values");
endmodule

//--- sim/ddpu_cpu_model.sv
/*
 * ddpu_cpu_model: core-side model issuing register accesses and pointer uses.
 * Assumes the bench calls its tasks; all signals change at the falling edge.
 */
`timescale 1ns/1ps
module ddpu_cpu_model
    import ddpu_pkg::*;
(
    // clock
    input wire logic core_clk,
    // requests toward the unit
    output ddpu_pkg::ddpu_sfr_req_t sfrReq,
    output ddpu_pkg::ddpu_use_t ptrUse,
    // read answer
    input wire logic [7:0] sfrRdata,
    input wire logic sfrHit
);
    import ddpu_pkg::*;
    ////////////////////////////////////////////////////////////////
    // idle lines carry junk so a stale address never looks valid
    initial begin
        sfrReq = '{rd: 1'b0, wr: 1'b0, addr: 8'h5A, wdata: 8'hA5};
        ptrUse = '0;
    end
    // one-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        sfrReq = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
        @(negedge core_clk);
        sfrReq = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
    endtask
    // one-cycle read, answer settled at the following falling edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic h);
        @(negedge core_clk);
        sfrReq = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h3C};
        @(negedge core_clk);
        d = sfrRdata;
        h = sfrHit;
        sfrReq = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: 8'hC3};
    endtask
    // one-cycle pointer use pulse
    task automatic mv(input logic x, input logic o);
        @(negedge core_clk);
        ptrUse = '{extMove: x, otherUse: o};
        @(negedge core_clk);
        ptrUse = '0;
    endtask
endmodule

//--- sim/dual_data_pointer_unit_bench.sv
/*
 * dual_data_pointer_unit_bench: directed checks of the dual pointer unit.
 * Assumes the core model drives the bus and pointer-use inputs; results sampled at falling edges.
 */
`timescale 1ns/1ps
module dual_data_pointer_unit_bench;
    import ddpu_pkg::*;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    ddpu_sfr_req_t sfrReq;
    ddpu_use_t ptrUse;
    logic [7:0] sfrRdata;
    logic sfrHit;
    logic [15:0] win;
    logic actSel;
    int n_mismatch = 0;
    int n_checks = 0;
    logic [7:0] rdat;
    logic rhit;
    ////////////////////////////////////////////////////////////////
    // 100 MHz core clock
    always #5 core_clk = ~core_clk;
    dual_data_pointer_unit #(.PTR_W(16)) dual_data_pointer_unit_i (.core_clk(core_clk), .reset(reset),
        .sfrReq(sfrReq), .sfrRdata(sfrRdata), .sfrHit(sfrHit), .ptrUse(ptrUse),
        .standardPointerWindow(win), .activePointerSelect(actSel));
    ddpu_cpu_model ddpu_cpu_model_i (.core_clk(core_clk), .sfrReq(sfrReq), .ptrUse(ptrUse),
        .sfrRdata(sfrRdata), .sfrHit(sfrHit));
    ////////////////////////////////////////////////////////////////
    // compare, narrower results zero-extended by callers
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        ddpu_cpu_model_i.wr(a, d);
    endtask
    task automatic setp(input logic [15:0] v);
        wr(8'h82, v[7:0]);
        wr(8'h83, v[15:8]);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] e, input logic h);
        ddpu_cpu_model_i.rd(a, rdat, rhit);
        chk({8'h00, rdat}, {8'h00, e});
        chk({15'h0000, rhit}, {15'h0000, h});
    endtask
    ////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_reset;
        chk(win, 16'h0000);
        chk({15'h0000, actSel}, 16'h0000);
        rdchk(8'h85, 8'h00, 1'b1);
        rdchk(8'h86, 8'h00, 1'b1);
    endtask
    task automatic t_window;
        setp(16'h1234);
        wr(8'h85, 8'h01);
        chk(win, 16'h0000);
        setp(16'hABCD);
        rdchk(8'h82, 8'hCD, 1'b1);
        rdchk(8'h83, 8'hAB, 1'b1);
        wr(8'h85, 8'h00);
        chk(win, 16'h1234);
    endtask
    // reserved bits drop, unmapped read answers zero without hit
    task automatic t_regs;
        wr(8'h85, 8'hFF);
        rdchk(8'h85, 8'h41, 1'b1);
        wr(8'h86, 8'hFF);
        rdchk(8'h86, 8'h0F, 1'b1);
        rdchk(8'h84, 8'h00, 1'b0);
        wr(8'h85, 8'h00);
        wr(8'h86, 8'h00);
    endtask
    // one step code on one pointer, background seeded with a marker
    task automatic step_chk(input logic s, input logic [1:0] c);
        logic [15:0] st;
        logic [15:0] e;
        st = s ? 16'h0000 : 16'hFFFF;
        e = (c == 2'h2) ? st + 16'h0001 : (c == 2'h3) ? st - 16'h0001 : st;
        wr(8'h85, {7'h00, ~s});
        setp(16'h5A5A);
        wr(8'h85, {7'h00, s});
        setp(st);
        wr(8'h86, s ? {4'h0, c, 2'h0} : {6'h00, c});
        ddpu_cpu_model_i.mv(1'b0, 1'b1);
        chk(win, st);
        ddpu_cpu_model_i.mv(1'b1, 1'b0);
        chk(win, e);
        wr(8'h85, {7'h00, ~s});
        chk(win, 16'h5A5A);
    endtask
    // block-copy pattern: step the used pointer, then swap
    task automatic t_swap;
        wr(8'h85, 8'h00);
        setp(16'h0100);
        wr(8'h85, 8'h01);
        setp(16'h0200);
        wr(8'h86, 8'h0A);
        wr(8'h85, 8'h41);
        ddpu_cpu_model_i.mv(1'b1, 1'b0);
        chk({15'h0000, actSel}, 16'h0000);
        chk(win, 16'h0100);
        ddpu_cpu_model_i.mv(1'b1, 1'b0);
        chk({15'h0000, actSel}, 16'h0001);
        chk(win, 16'h0201);
    endtask
    ////////////////////////////////////////////////////////////////
    // main sequence: reset held two cycles, released off the sampling edge
    initial begin
        repeat (2) @(negedge core_clk);
        reset = 1'b0;
        t_reset();
        t_window();
        t_regs();
        for (int i = 0; i < 8; i++) step_chk(i[2], i[1:0]);
        t_swap();
        complete_run();
    end
    // watchdog, far beyond the few hundred cycles the run needs
    initial begin
        #100000;
        n_mismatch++;
        complete_run();
    end
endmodule
